// *** verilog/sbt_pkg.sv ***
// Package of register map, field layout and mode codes for the 16-bit timer
package sbt_pkg;
   localparam int SBT_AW = 5;
   localparam int SBT_DW = 32;
   localparam int SBT_CNT_W = 16;
   localparam int SBT_CTRL_W = 9;
   // Register byte offsets
   localparam logic [SBT_AW-1:0] SBT_OFS_CTRL = 5'h00;
   localparam logic [SBT_AW-1:0] SBT_OFS_COUNT = 5'h04;
   localparam logic [SBT_AW-1:0] SBT_OFS_CMP_A = 5'h08;
   localparam logic [SBT_AW-1:0] SBT_OFS_CMP_B = 5'h0c;
   localparam logic [SBT_AW-1:0] SBT_OFS_STAT = 5'h10;
   localparam logic [SBT_AW-1:0] SBT_OFS_MASK = 5'h14;
   // Fields of timer_mode_control
   localparam int SBT_RUN_LO = 2;
   localparam int SBT_CKS_LO = 4;
   localparam int SBT_CAP_BIT = 6;
   localparam int SBT_EDGE_LO = 7;
   // Run modes
   localparam logic [1:0] SBT_RUN_STOP = 2'h0;
   localparam logic [1:0] SBT_RUN_FREE = 2'h1;
   localparam logic [1:0] SBT_RUN_CLR_EDGE = 2'h2;
   localparam logic [1:0] SBT_RUN_CLR_MATCH = 2'h3;
   // Count clock sources
   localparam logic [1:0] SBT_CKS_PERIPH = 2'h0;
   localparam logic [1:0] SBT_CKS_SUB = 2'h1;
   localparam logic [1:0] SBT_CKS_TMR_C = 2'h2;
   localparam logic [1:0] SBT_CKS_EXT = 2'h3;
   // Edge selections
   localparam logic [1:0] SBT_EDGE_RISE = 2'h0;
   localparam logic [1:0] SBT_EDGE_FALL = 2'h1;
   localparam logic [1:0] SBT_EDGE_BOTH = 2'h2;
   localparam logic [1:0] SBT_EDGE_NONE = 2'h3;
   // Interrupt status bits
   localparam int SBT_IRQ_W = 4;
   localparam int SBT_IRQ_MATCH_A = 0;
   localparam int SBT_IRQ_MATCH_B = 1;
   localparam int SBT_IRQ_CAPTURE = 2;
   localparam int SBT_IRQ_OVF = 3;
   // Reset values
   localparam logic [SBT_CTRL_W-1:0] SBT_CTRL_RST = 9'h000;
   localparam logic [SBT_CNT_W-1:0] SBT_REG_RST = 16'h0000;
   localparam logic [SBT_IRQ_W-1:0] SBT_IRQ_RST = 4'h0;
   typedef enum logic [1:0] {
      SBT_BUS_IDLE = 2'b01,
      SBT_BUS_ACK = 2'b10
   } sbt_bus_e;
endpackage : sbt_pkg

// *** verilog/sbt_edge_if.sv ***
// Interface between the timer core and one edge detector
`timescale 1ns/100ps
interface sbt_edge_if;
   logic level;
   logic [1:0] edge_mode;
   logic pulse;
   modport det (input level, input edge_mode, output pulse);
   modport user (output level, output edge_mode, input pulse);
endinterface : sbt_edge_if

// *** verilog/sbt_edge_det.sv ***
// Edge detector for one synchronous timer input
`timescale 1ns/100ps
module sbt_edge_det
   import sbt_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   sbt_edge_if.det e
);
   logic prev_r;

   // Previous level resets low, so a pin already high at release looks like a rise
   always_ff @(posedge clk) begin
      if (rst) begin
         prev_r <= 1'b0;
      end else begin
         prev_r <= e.level;
      end
   end

   always_comb begin
      unique case (e.edge_mode)
         SBT_EDGE_RISE: e.pulse = e.level & ~prev_r;
         SBT_EDGE_FALL: e.pulse = ~e.level & prev_r;
         SBT_EDGE_BOTH: e.pulse = e.level ^ prev_r;
         default: e.pulse = 1'b0;
      endcase
   end
endmodule : sbt_edge_det

// *** verilog/sbt_timer.sv ***
// Sixteen-bit timer and event counter with Avalon-MM registers
// What this block does
// - The count clock is chosen from the peripheral clock, subsystem clock, timer C output or input pin only.
// - In interval mode a match raises an interrupt request each time the interval elapses.
// - In event counter mode the counter counts pulses on the external input.
// - In measurement mode the input edge captures the counter value to find the pulse width.
// - The block holds a 16-bit up-counter, a compare register, a capture/compare register and an output.
// - Stopping the counter in the same cycle as a capture trigger still captures the counter value.
// - A captured value stays until reset or rewrite, and software writes a fresh compare value.
// - The counter starts when the run bits become non-zero and stops when they are written to zero.
// - The counter steps on each rising count clock edge and clears when the run bits are zero.
// - In compare mode a match on the second register raises its interrupt and captures are ignored.
`timescale 1ns/100ps
module sbt_timer
   import sbt_pkg::*;
#(
   parameter int CNT_W = SBT_CNT_W
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [sbt_pkg::SBT_AW-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [sbt_pkg::SBT_DW-1:0] avs_writedata,
   output logic [sbt_pkg::SBT_DW-1:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic sub_clock_in,
   input wire logic eight_bit_timer_c_output,
   input wire logic ext_timer_input,
   output logic timer_out,
   output logic match_irq_b,
   output logic irq
);
   import sbt_pkg::*;

   if (CNT_W != SBT_CNT_W) begin : g_width_check
      $error("sbt_timer: counter width must be 16");
   end

   sbt_bus_e bus_r;
   logic [SBT_CTRL_W-1:0] timer_mode_control_r;
   logic [CNT_W-1:0] up_counter_r;
   logic [CNT_W-1:0] up_counter_nxt;
   logic [CNT_W-1:0] compare_reg_a_r;
   logic [CNT_W-1:0] capture_compare_reg_b_r;
   logic [SBT_IRQ_W-1:0] stat_r;
   logic [SBT_IRQ_W-1:0] stat_nxt;
   logic [SBT_IRQ_W-1:0] mask_r;
   logic [SBT_IRQ_W-1:0] events;
   logic [SBT_DW-1:0] rdata_r;
   logic timer_out_r;
   logic match_irq_b_r;
   logic irq_r;
   logic [1:0] run_mode;
   logic [1:0] clk_sel;
   logic cap_mode;
   logic running;
   logic tick;
   logic step;
   logic match_a;
   logic match_b;
   logic capture;
   logic ovf;
   logic wr_en;
   logic wr_ctrl;
   logic wr_b;

   assign run_mode = timer_mode_control_r[SBT_RUN_LO +: 2];
   assign clk_sel = timer_mode_control_r[SBT_CKS_LO +: 2];
   assign cap_mode = timer_mode_control_r[SBT_CAP_BIT];
   assign running = run_mode != SBT_RUN_STOP;

   // Edge detectors: count sources always rise, capture edge is programmable
   sbt_edge_if sub_e ();
   sbt_edge_if tmc_e ();
   sbt_edge_if ext_e ();
   sbt_edge_if cap_e ();
   assign sub_e.level = sub_clock_in;
   assign sub_e.edge_mode = SBT_EDGE_RISE;
   assign tmc_e.level = eight_bit_timer_c_output;
   assign tmc_e.edge_mode = SBT_EDGE_RISE;
   assign ext_e.level = ext_timer_input;
   assign ext_e.edge_mode = SBT_EDGE_RISE;
   assign cap_e.level = ext_timer_input;
   assign cap_e.edge_mode = timer_mode_control_r[SBT_EDGE_LO +: 2];

   sbt_edge_det u_sub (.clk(clk), .rst(rst), .e(sub_e.det));
   sbt_edge_det u_tmc (.clk(clk), .rst(rst), .e(tmc_e.det));
   sbt_edge_det u_ext (.clk(clk), .rst(rst), .e(ext_e.det));
   sbt_edge_det u_cap (.clk(clk), .rst(rst), .e(cap_e.det));

   // Only four sources are wired; slow oscillator and other timers never reach the mux
   always_comb begin
      unique case (clk_sel)
         SBT_CKS_PERIPH: tick = 1'b1;
         SBT_CKS_SUB: tick = sub_e.pulse;
         SBT_CKS_TMR_C: tick = tmc_e.pulse;
         SBT_CKS_EXT: tick = ext_e.pulse;
      endcase
   end

   // Counter next value
   always_comb begin
      up_counter_nxt = up_counter_r;
      step = 1'b0;
      if (!running) begin
         up_counter_nxt = SBT_REG_RST;
      end else if (run_mode == SBT_RUN_CLR_EDGE && cap_e.pulse) begin
         up_counter_nxt = SBT_REG_RST;
      end else if (tick) begin
         step = 1'b1;
         if (run_mode == SBT_RUN_CLR_MATCH && up_counter_r == compare_reg_a_r) begin
            up_counter_nxt = SBT_REG_RST;
         end else begin
            up_counter_nxt = CNT_W'(up_counter_r + 1'b1);
         end
      end
   end

   assign match_a = step && up_counter_nxt == compare_reg_a_r;
   assign match_b = step && !cap_mode && up_counter_nxt == capture_compare_reg_b_r;
   assign ovf = step && run_mode != SBT_RUN_CLR_MATCH && up_counter_r == {CNT_W{1'b1}};
   // Capture is ignored in compare mode
   assign capture = running && cap_mode && cap_e.pulse;
   assign events = {ovf, capture, match_b, match_a};

   always_ff @(posedge clk) begin
      if (rst) begin
         up_counter_r <= SBT_REG_RST;
      end else begin
         up_counter_r <= up_counter_nxt;
      end
   end

   // Avalon slave: one wait cycle, then the access completes
   assign avs_waitrequest = (avs_read || avs_write) && bus_r == SBT_BUS_IDLE;
   assign wr_en = avs_write && bus_r == SBT_BUS_ACK;
   assign wr_ctrl = wr_en && avs_address == SBT_OFS_CTRL;
   assign wr_b = wr_en && avs_address == SBT_OFS_CMP_B;

   always_ff @(posedge clk) begin
      if (rst) begin
         bus_r <= SBT_BUS_IDLE;
      end else begin
         unique case (bus_r)
            SBT_BUS_IDLE: begin
               if (avs_read || avs_write) begin
                  bus_r <= SBT_BUS_ACK;
               end
            end
            SBT_BUS_ACK: bus_r <= SBT_BUS_IDLE;
            default: bus_r <= SBT_BUS_IDLE;
         endcase
      end
   end

   // Read data is sampled in the wait cycle; unmapped offsets read zero
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_r <= '0;
      end else if (avs_read && bus_r == SBT_BUS_IDLE) begin
         unique case (avs_address)
            SBT_OFS_CTRL: rdata_r <= SBT_DW'(timer_mode_control_r);
            SBT_OFS_COUNT: rdata_r <= SBT_DW'(up_counter_r);
            SBT_OFS_CMP_A: rdata_r <= SBT_DW'(compare_reg_a_r);
            SBT_OFS_CMP_B: rdata_r <= SBT_DW'(capture_compare_reg_b_r);
            SBT_OFS_STAT: rdata_r <= SBT_DW'(stat_r);
            SBT_OFS_MASK: rdata_r <= SBT_DW'(mask_r);
            default: rdata_r <= '0;
         endcase
      end
   end
   assign avs_readdata = rdata_r;

   always_ff @(posedge clk) begin
      if (rst) begin
         timer_mode_control_r <= SBT_CTRL_RST;
      end else if (wr_ctrl) begin
         timer_mode_control_r <= avs_writedata[SBT_CTRL_W-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         compare_reg_a_r <= SBT_REG_RST;
      end else if (wr_en && avs_address == SBT_OFS_CMP_A) begin
         compare_reg_a_r <= avs_writedata[CNT_W-1:0];
      end
   end

   // Capture beats a software write in the same cycle; nothing else clears it
   always_ff @(posedge clk) begin
      if (rst) begin
         capture_compare_reg_b_r <= SBT_REG_RST;
      end else if (capture) begin
         capture_compare_reg_b_r <= up_counter_r;
      end else if (wr_b) begin
         capture_compare_reg_b_r <= avs_writedata[CNT_W-1:0];
      end
   end

   // Sticky status: a new event wins over a write-one clear
   always_comb begin
      stat_nxt = stat_r;
      if (wr_en && avs_address == SBT_OFS_STAT) begin
         stat_nxt = stat_r & ~avs_writedata[SBT_IRQ_W-1:0];
      end
      stat_nxt = stat_nxt | events;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         stat_r <= SBT_IRQ_RST;
      end else begin
         stat_r <= stat_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         mask_r <= SBT_IRQ_RST;
      end else if (wr_en && avs_address == SBT_OFS_MASK) begin
         mask_r <= avs_writedata[SBT_IRQ_W-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(stat_r & mask_r);
      end
   end
   assign irq = irq_r;

   // Output controller toggles on each compare A match
   always_ff @(posedge clk) begin
      if (rst) begin
         timer_out_r <= 1'b0;
      end else if (match_a) begin
         timer_out_r <= ~timer_out_r;
      end
   end
   assign timer_out = timer_out_r;

   always_ff @(posedge clk) begin
      if (rst) begin
         match_irq_b_r <= 1'b0;
      end else begin
         match_irq_b_r <= match_b;
      end
   end
   assign match_irq_b = match_irq_b_r;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence start_wr_s;
      wr_ctrl && avs_writedata[SBT_RUN_LO +: 2] != SBT_RUN_STOP;
   endsequence

   sequence stop_wr_s;
      wr_ctrl && avs_writedata[SBT_RUN_LO +: 2] == SBT_RUN_STOP;
   endsequence

   count_source_a: assert property (
      (running && clk_sel == SBT_CKS_SUB && !sub_clock_in) |-> !step)
      else $error("count stepped without subsystem clock edge");

   start_run_a: assert property (start_wr_s |=> running)
      else $error("counter did not start on non-zero run bits");

   stop_clear_a: assert property (stop_wr_s |=> !running ##1 up_counter_r == '0)
      else $error("counter not cleared after stop");

   free_step_a: assert property (
      (running && run_mode == SBT_RUN_FREE && tick && !cap_e.pulse && !wr_ctrl)
      |=> up_counter_r == CNT_W'($past(up_counter_r) + 1'b1))
      else $error("counter did not step on count clock");

   event_count_a: assert property (
      (run_mode == SBT_RUN_FREE && clk_sel == SBT_CKS_EXT && !wr_ctrl
       && !ext_e.pulse && !cap_e.pulse) |=> $stable(up_counter_r))
      else $error("event counter moved without input pulse");

   interval_irq_a: assert property (match_a |=> stat_r[SBT_IRQ_MATCH_A] ##1
      (irq || !mask_r[SBT_IRQ_MATCH_A] || $past(wr_en)))
      else $error("interval match did not raise request");

   capture_value_a: assert property (capture |=>
      capture_compare_reg_b_r == $past(up_counter_r) && stat_r[SBT_IRQ_CAPTURE])
      else $error("capture did not record counter");

   stop_capture_a: assert property ((stop_wr_s and capture) |=>
      capture_compare_reg_b_r == $past(up_counter_r))
      else $error("capture lost when stopping");

   hold_capture_a: assert property ((!capture && !wr_b) |=>
      $stable(capture_compare_reg_b_r))
      else $error("capture register changed without cause");

   match_b_irq_a: assert property (match_b |=> match_irq_b ##0
      stat_r[SBT_IRQ_MATCH_B])
      else $error("compare B match not reported");

   ignore_capture_a: assert property ((!cap_mode && cap_e.pulse && !wr_b) |=>
      $stable(capture_compare_reg_b_r))
      else $error("capture taken in compare mode");

   stopped_zero_a: assert property (!running |=> up_counter_r == '0)
      else $error("counter not held at zero while stopped");

   clear_match_a: assert property (
      (step && run_mode == SBT_RUN_CLR_MATCH && up_counter_r == compare_reg_a_r)
      |=> up_counter_r == '0)
      else $error("interval counter did not restart on match");

   edge_clear_a: assert property (
      (running && run_mode == SBT_RUN_CLR_EDGE && cap_e.pulse) |=> up_counter_r == '0)
      else $error("counter did not restart on input edge");

   toggle_out_a: assert property (match_a |=> timer_out != $past(timer_out))
      else $error("output did not toggle on compare match");

   irq_set_a: assert property ((|(stat_r & mask_r)) |=> irq)
      else $error("unmasked status did not raise irq");

   irq_clear_a: assert property (!(|(stat_r & mask_r)) |=> !irq)
      else $error("irq high without unmasked status");

   status_hold_a: assert property (
      (stat_r[SBT_IRQ_MATCH_A] && !(wr_en && avs_address == SBT_OFS_STAT
       && avs_writedata[SBT_IRQ_MATCH_A])) |=> stat_r[SBT_IRQ_MATCH_A])
      else $error("match status lost without a clear");

   clear_b_a: assert property (
      (wr_en && avs_address == SBT_OFS_STAT && avs_writedata[SBT_IRQ_MATCH_B] && !match_b)
      |=> !stat_r[SBT_IRQ_MATCH_B])
      else $error("match b status not cleared by write");
endmodule : sbt_timer

// *** sim/sbt_pulse_src.sv ***
// Model of the external pulse source on the timer input pin
`timescale 1ns/100ps
module sbt_pulse_src (
   input wire logic clk,
   output logic pin
);
   // Idle low between pulses, as a pulled-down pin would sit
   initial pin = 1'b0;
   // Whole pulses only: high for hi cycles, then low for lo cycles plus one
   // Called while the core counts the pin or runs from its main clock, and once as a stop write lands
   task automatic burst(input int n, input int hi, input int lo);
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         pin <= 1'b1;
         repeat (hi) @(posedge clk);
         pin <= 1'b0;
         repeat (lo) @(posedge clk);
      end
   endtask : burst
endmodule : sbt_pulse_src

// *** sim/tb_top.sv ***
// Self-checking bench for the 16-bit timer: bus, counting, capture and interrupts
`timescale 1ns/100ps
module tb_top;
   import sbt_pkg::*;
   typedef struct {string nm; logic [31:0] exp; logic [31:0] msk;} sbt_note_s;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [SBT_AW-1:0] avs_address = '0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [SBT_DW-1:0] avs_writedata = '0;
   logic [SBT_DW-1:0] avs_readdata;
   logic avs_waitrequest;
   logic [1:0] tick_v = 2'h0;
   logic pin;
   logic timer_out;
   logic to_q;
   logic match_irq_b;
   logic irq;
   sbt_note_s notes[$];
   sbt_note_s n_note;
   int error_cnt = 0;
   int check_count = 0;
   int cyc = 0;
   int mb_cnt = 0;
   int tog_cnt = 0;
   int k, mb0, tog0;
   logic [31:0] seed = 32'h37b5;
   logic [31:0] v1, d, n;
   always #2 clk = ~clk;
   sbt_timer u_dut (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .sub_clock_in(tick_v[0]),
      .eight_bit_timer_c_output(tick_v[1]), .ext_timer_input(pin), .timer_out(timer_out),
      .match_irq_b(match_irq_b), .irq(irq));
   sbt_pulse_src u_src (.clk(clk), .pin(pin));
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   function automatic logic [31:0] ctl(logic [1:0] run, logic [1:0] cks, logic cap,
                                       logic [1:0] edg);
      return (32'(run) << SBT_RUN_LO) | (32'(cks) << SBT_CKS_LO) | (32'(cap) << SBT_CAP_BIT)
         | (32'(edg) << SBT_EDGE_LO);
   endfunction : ctl
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic end_of_test();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : end_of_test
   // Request held until waitrequest is seen low at a rising edge, then released
   task automatic bus(input logic wr_en, input logic [4:0] a, input logic [31:0] wd,
                      output logic [31:0] q);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= wd;
      avs_read <= ~wr_en;
      avs_write <= wr_en;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0) @(posedge clk);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus
   task automatic wr(input logic [4:0] a, input logic [31:0] wd);
      logic [31:0] q;
      bus(1'b1, a, wd, q);
   endtask : wr
   task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m,
                     input string nm, output logic [31:0] q);
      notes.push_back('{nm, e & m, m});
      bus(1'b0, a, 32'h0, q);
   endtask : rd
   // Result watcher: each completed read takes the oldest note
   always @(posedge clk) begin
      cyc++;
      if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
         n_note = notes.pop_front();
         chk(n_note.nm, avs_readdata & n_note.msk, n_note.exp);
      end
      if (match_irq_b === 1'b1) mb_cnt++;
      if (timer_out !== to_q) tog_cnt++;
      to_q = timer_out;
      if (cyc == 10000) begin
         error_cnt++;
         end_of_test();
      end
   end
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      // Offset 0x18 is unmapped and must read zero too
      for (int a = 0; a <= 'h18; a += 4) rd(5'(a), 32'h0, 32'hffffffff, "reset value", v1);
      d = xs();
      wr(SBT_OFS_CMP_A, d);
      rd(SBT_OFS_CMP_A, d & 32'hffff, 32'hffffffff, "compare a width", v1);
      wr(SBT_OFS_CMP_B, ~d);
      rd(SBT_OFS_CMP_B, ~d & 32'hffff, 32'hffffffff, "compare b width", v1);
      // Each external tick source in turn; 1 sub, 2 timer C, 3 pin
      for (int s = 1; s < 4; s++) begin
         k = 1 + int'(xs() % 8);
         wr(SBT_OFS_CTRL, ctl(SBT_RUN_FREE, 2'(s), 1'b0, SBT_EDGE_NONE));
         if (s == 3) u_src.burst(k, 2, 3);
         else for (int i = 0; i < k; i++) begin
            @(posedge clk) tick_v[s-1] <= 1'b1;
            repeat (2) @(posedge clk);
            tick_v[s-1] <= 1'b0;
            repeat (3) @(posedge clk);
         end
         repeat (4) @(posedge clk);
         rd(SBT_OFS_COUNT, 32'(k), 32'hffff, "event count", v1);
         wr(SBT_OFS_CTRL, 32'h0);
         rd(SBT_OFS_COUNT, 32'h0, 32'hffff, "stopped count", v1);
      end
      n = 4 + xs() % 16;
      wr(SBT_OFS_CMP_A, n);
      wr(SBT_OFS_MASK, 32'h1);
      tog0 = tog_cnt;
      wr(SBT_OFS_CTRL, ctl(SBT_RUN_CLR_MATCH, SBT_CKS_PERIPH, 1'b0, SBT_EDGE_NONE));
      repeat (3 * (n + 1)) @(posedge clk);
      chk("timer out toggles", 32'(tog_cnt - tog0 >= 2), 32'h1);
      chk("irq raised", irq, 32'h1);
      rd(SBT_OFS_STAT, 32'h1, 32'h5, "status match a", v1);
      wr(SBT_OFS_MASK, 32'h0);
      repeat (3) @(posedge clk);
      chk("irq masked", irq, 32'h0);
      wr(SBT_OFS_CTRL, 32'h0);
      wr(SBT_OFS_STAT, 32'h1);
      wr(SBT_OFS_MASK, 32'h1);
      repeat (3) @(posedge clk);
      chk("irq cleared", irq, 32'h0);
      rd(SBT_OFS_STAT, 32'h0, 32'h1, "status cleared", v1);
      // Compare mode on the second register: match pulses once, pin edges are ignored
      d = 8 + xs() % 200;
      wr(SBT_OFS_CMP_B, d);
      wr(SBT_OFS_STAT, 32'hf);
      mb0 = mb_cnt;
      wr(SBT_OFS_CTRL, ctl(SBT_RUN_FREE, SBT_CKS_PERIPH, 1'b0, SBT_EDGE_RISE));
      u_src.burst(2, 3, 3);
      repeat (d + 10) @(posedge clk);
      wr(SBT_OFS_CTRL, 32'h0);
      chk("match b pulses", 32'(mb_cnt - mb0), 32'h1);
      rd(SBT_OFS_CMP_B, d, 32'hffff, "b ignores capture", v1);
      rd(SBT_OFS_STAT, 32'h2, 32'h6, "status match b", v1);
      // Width of a 40-cycle pulse from captures on both edges
      wr(SBT_OFS_STAT, 32'hf);
      wr(SBT_OFS_CTRL, ctl(SBT_RUN_FREE, SBT_CKS_PERIPH, 1'b1, SBT_EDGE_BOTH));
      fork
         u_src.burst(1, 40, 4);
         begin
            repeat (8) @(posedge clk);
            rd(SBT_OFS_CMP_B, 32'h1, 32'hffff, "first capture", v1);
         end
      join
      rd(SBT_OFS_CMP_B, v1 + 40, 32'hffff, "pulse width", d);
      rd(SBT_OFS_STAT, 32'h4, 32'h4, "status capture", d);
      wr(SBT_OFS_CTRL, 32'h0);
      wr(SBT_OFS_CTRL, ctl(SBT_RUN_STOP, SBT_CKS_PERIPH, 1'b0, SBT_EDGE_NONE));
      rd(SBT_OFS_CMP_B, v1 + 40, 32'hffff, "kept capture", d);
      wr(SBT_OFS_CMP_B, 32'h1234);
      rd(SBT_OFS_CMP_B, 32'h1234, 32'hffffffff, "fresh compare", d);
      // Clear on pin edge: rising edges 23 cycles apart capture the count before clearing
      wr(SBT_OFS_CTRL, ctl(SBT_RUN_CLR_EDGE, SBT_CKS_PERIPH, 1'b1, SBT_EDGE_RISE));
      u_src.burst(2, 2, 20);
      rd(SBT_OFS_CMP_B, 32'd22, 32'hffff, "edge period", d);
      // Stop write and capture edge in one cycle: the capture is still taken
      wr(SBT_OFS_STAT, 32'hf);
      fork
         wr(SBT_OFS_CTRL, 32'h0);
         begin
            @(posedge clk);
            u_src.burst(1, 2, 2);
         end
      join
      rd(SBT_OFS_STAT, 32'h4, 32'h4, "stop capture", d);
      // Falling edge only: the rise 30 cycles before it is no trigger
      wr(SBT_OFS_CTRL, ctl(SBT_RUN_FREE, SBT_CKS_PERIPH, 1'b1, SBT_EDGE_FALL));
      u_src.burst(1, 30, 4);
      rd(SBT_OFS_CMP_B, 32'd31, 32'hffff, "fall capture", d);
      wr(SBT_OFS_CTRL, 32'h0);
      // Reset while stopped wipes the kept capture and the status
      @(posedge clk) rst <= 1'b1;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      rd(SBT_OFS_CMP_B, 32'h0, 32'hffffffff, "reset clears capture", d);
      rd(SBT_OFS_STAT, 32'h0, 32'hffffffff, "reset clears status", d);
      end_of_test();
   end
endmodule : tb_top
